// >>> logic/lopc_clk_div.v
`timescale 1ns/100ps
// pump clock divider from the core system clock
module lopc_clk_div #(
  parameter DIV_W = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire enable,
  input wire [DIV_W-1:0] half_period,
  output reg pump_clk
);
  reg [DIV_W-1:0] count;
  // stops low when disabled so the pump idles quietly
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {DIV_W{1'b0}};
      pump_clk <= 1'b0;
    end else if (!enable) begin
      count <= {DIV_W{1'b0}};
      pump_clk <= 1'b0;
    end else if (count >= half_period) begin
      count <= {DIV_W{1'b0}};
      pump_clk <= ~pump_clk;
    end else begin
      count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// >>> logic/lopc_map.vh
`ifndef LOPC_MAP_VH
`define LOPC_MAP_VH
`define LOPC_IDX_VOLMUTE 8'h1e
`define LOPC_IDX_MIXER 8'h35
`define LOPC_IDX_PUMP 8'h4c
`define LOPC_IDX_POLICY 8'h51
`define LOPC_IDX_HPVOL 8'he0
`define LOPC_RST_VOLMUTE 16'h0006
`define LOPC_RST_MIXER 16'h0000
`define LOPC_RST_PUMP 16'h1f25
`define LOPC_RST_POLICY 16'h0000
`define LOPC_RST_HPVOL 16'h0000
`define LOPC_MASK_VOLMUTE 16'h0007
`define LOPC_MASK_MIXER 16'h0077
`define LOPC_MASK_POLICY 16'h0001
`define LOPC_BIT_NMUTE 2
`define LOPC_BIT_PMUTE 1
`define LOPC_BIT_VOL 0
`define LOPC_BIT_RMIX_N 6
`define LOPC_BIT_LMIX_N 5
`define LOPC_BIT_MODE 4
`define LOPC_BIT_LAMP 2
`define LOPC_BIT_RAMP 1
`define LOPC_BIT_RMIX_P 0
`define LOPC_BIT_PUMP_ON 15
`define LOPC_BIT_DYN 0
`define LOPC_HP_L_MSB 5
`define LOPC_HP_R_LSB 8
`define LOPC_HP_R_MSB 13
`define LOPC_HP_L_EN 6
`define LOPC_HP_R_EN 14
`define LOPC_HTRANS_NONSEQ 2'h2
`define LOPC_HSIZE_WORD 3'h2
`endif

// >>> logic/lopc_pump_level.v
`timescale 1ns/100ps
// pump level select: volume based or signal based
module lopc_pump_level #(
  parameter VOL_W = 6,
  parameter LVL_W = 8,
  parameter [VOL_W-1:0] VOL_HIGH = 6'h30,
  parameter [LVL_W-1:0] LVL_HIGH = 8'h40
) (
  input wire [VOL_W-1:0] left_phones_volume,
  input wire [VOL_W-1:0] right_phones_volume,
  input wire [LVL_W-1:0] dac_level,
  input wire pump_level_tracking,
  output wire high_rail
);
  wire vol_high;
  wire sig_high;
  // loud volume needs the wider rails
  assign vol_high = (left_phones_volume >= VOL_HIGH) ||
                    (right_phones_volume >= VOL_HIGH);
  assign sig_high = (dac_level >= LVL_HIGH);
  assign high_rail = pump_level_tracking ? sig_high : vol_high;
endmodule

// >>> logic/lopc_top.v
`timescale 1ns/100ps
`include "lopc_map.vh"
// line output pair 2 and charge pump control registers over ahb-lite
module lopc_top #(
  parameter DIV_W = 4,
  parameter [DIV_W-1:0] PUMP_HALF = 4'h7,
  parameter LVL_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [LVL_W-1:0] dac_level,
  output reg line2_neg_leg_mute,
  output reg line2_pos_leg_mute,
  output reg line2_atten_step,
  output reg line2_ended_select,
  output reg right_mix_to_neg_leg,
  output reg left_mix_to_neg_leg,
  output reg left_amp_to_diff_out,
  output reg right_amp_to_diff_out,
  output reg right_mix_to_diff,
  output reg right_mix_to_pos_leg,
  output reg pump_on,
  output reg pump_high_rail,
  output reg pump_clk,
  output reg left_phones_driver_on,
  output reg right_phones_driver_on
);
  reg [15:0] reg_volmute;
  reg [15:0] reg_mixer;
  reg [15:0] reg_pump;
  reg [15:0] reg_policy;
  reg [15:0] reg_hpvol;
  reg wr_pend;
  reg [7:0] wr_idx;
  reg [LVL_W-1:0] lvl_s1;
  reg [LVL_W-1:0] lvl_s2;
  reg [LVL_W-1:0] lvl_s3;
  reg [LVL_W-1:0] lvl_hold;
  reg [15:0] next_rd;
  wire [7:0] idx_in;
  wire take;
  wire high_rail;
  wire div_clk;

  // word index from byte address
  assign idx_in = haddr[9:2];
  assign take = hsel && hready && (htrans == `LOPC_HTRANS_NONSEQ);

  // read mux; reserved bits read zero, except bits 7 and 15 of reg_hpvol, which read back as written
  always @* begin
    case (idx_in)
      `LOPC_IDX_VOLMUTE: next_rd = reg_volmute;
      `LOPC_IDX_MIXER: next_rd = reg_mixer;
      `LOPC_IDX_PUMP: next_rd = reg_pump;
      `LOPC_IDX_POLICY: next_rd = reg_policy;
      `LOPC_IDX_HPVOL: next_rd = reg_hpvol;
      default: next_rd = 16'h0000;
    endcase
  end

  // bus slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      wr_idx <= idx_in;
      if (take && !hwrite) begin
        hrdata <= {16'h0000, next_rd};
      end
    end
  end

  // register file; data phase write lands one edge after address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_volmute <= `LOPC_RST_VOLMUTE;
      reg_mixer <= `LOPC_RST_MIXER;
      reg_pump <= `LOPC_RST_PUMP;
      reg_policy <= `LOPC_RST_POLICY;
      reg_hpvol <= `LOPC_RST_HPVOL;
    end else if (wr_pend) begin
      case (wr_idx)
        `LOPC_IDX_VOLMUTE: reg_volmute <= hwdata[15:0] & `LOPC_MASK_VOLMUTE;
        `LOPC_IDX_MIXER: reg_mixer <= hwdata[15:0] & `LOPC_MASK_MIXER;
        // low bits stored as written; keeping the pattern is up to software
        `LOPC_IDX_PUMP: reg_pump <= hwdata[15:0];
        `LOPC_IDX_POLICY: reg_policy <= hwdata[15:0] & `LOPC_MASK_POLICY;
        `LOPC_IDX_HPVOL: reg_hpvol <= hwdata[15:0];
        default: reg_hpvol <= reg_hpvol;
      endcase
    end
  end

  // dac level comes from another domain: two stages before use;
  // bits may land in different cycles, so a word is used only once
  // two synced samples agree, at the cost of two cycles of latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_s1 <= {LVL_W{1'b0}};
      lvl_s2 <= {LVL_W{1'b0}};
      lvl_s3 <= {LVL_W{1'b0}};
      lvl_hold <= {LVL_W{1'b0}};
    end else begin
      lvl_s1 <= dac_level;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
      if (lvl_s2 == lvl_s3) begin
        lvl_hold <= lvl_s3;
      end
    end
  end

  lopc_pump_level #(
    .VOL_W(6),
    .LVL_W(LVL_W)
  ) u_level (
    .left_phones_volume(reg_hpvol[`LOPC_HP_L_MSB:0]),
    .right_phones_volume(reg_hpvol[`LOPC_HP_R_MSB:`LOPC_HP_R_LSB]),
    .dac_level(lvl_hold),
    .pump_level_tracking(reg_policy[`LOPC_BIT_DYN]),
    .high_rail(high_rail)
  );

  lopc_clk_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(reg_pump[`LOPC_BIT_PUMP_ON]),
    .half_period(PUMP_HALF),
    .pump_clk(div_clk)
  );

  // registered outputs; mode gates routing without touching stored bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line2_neg_leg_mute <= 1'b1;
      line2_pos_leg_mute <= 1'b1;
      line2_atten_step <= 1'b0;
      line2_ended_select <= 1'b0;
      right_mix_to_neg_leg <= 1'b0;
      left_mix_to_neg_leg <= 1'b0;
      left_amp_to_diff_out <= 1'b0;
      right_amp_to_diff_out <= 1'b0;
      right_mix_to_diff <= 1'b0;
      right_mix_to_pos_leg <= 1'b0;
      pump_on <= 1'b0;
      pump_high_rail <= 1'b0;
      pump_clk <= 1'b0;
      left_phones_driver_on <= 1'b0;
      right_phones_driver_on <= 1'b0;
    end else begin
      line2_neg_leg_mute <= reg_volmute[`LOPC_BIT_NMUTE];
      line2_pos_leg_mute <= reg_volmute[`LOPC_BIT_PMUTE];
      line2_atten_step <= reg_volmute[`LOPC_BIT_VOL];
      line2_ended_select <= reg_mixer[`LOPC_BIT_MODE];
      right_mix_to_neg_leg <= reg_mixer[`LOPC_BIT_MODE] &
                              reg_mixer[`LOPC_BIT_RMIX_N];
      left_mix_to_neg_leg <= reg_mixer[`LOPC_BIT_MODE] &
                             reg_mixer[`LOPC_BIT_LMIX_N];
      left_amp_to_diff_out <= ~reg_mixer[`LOPC_BIT_MODE] &
                              reg_mixer[`LOPC_BIT_LAMP];
      right_amp_to_diff_out <= ~reg_mixer[`LOPC_BIT_MODE] &
                               reg_mixer[`LOPC_BIT_RAMP];
      right_mix_to_diff <= ~reg_mixer[`LOPC_BIT_MODE] &
                           reg_mixer[`LOPC_BIT_RMIX_P];
      right_mix_to_pos_leg <= reg_mixer[`LOPC_BIT_MODE] &
                              reg_mixer[`LOPC_BIT_RMIX_P];
      pump_on <= reg_pump[`LOPC_BIT_PUMP_ON];
      pump_high_rail <= reg_pump[`LOPC_BIT_PUMP_ON] & high_rail;
      pump_clk <= div_clk;
      left_phones_driver_on <= reg_hpvol[`LOPC_HP_L_EN];
      right_phones_driver_on <= reg_hpvol[`LOPC_HP_R_EN];
    end
  end
endmodule

// >>> testbench/lopc_sva.sv
`timescale 1ns/100ps
module lopc_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire line2_neg_leg_mute,
  input wire line2_pos_leg_mute,
  input wire line2_atten_step,
  input wire line2_ended_select,
  input wire right_mix_to_neg_leg,
  input wire left_mix_to_neg_leg,
  input wire left_amp_to_diff_out,
  input wire right_amp_to_diff_out,
  input wire right_mix_to_diff,
  input wire right_mix_to_pos_leg,
  input wire pump_on,
  input wire pump_high_rail,
  input wire pump_clk
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write address phase aimed at the volume and mute word
  wire vol_wr = hsel && hready && htrans == 2'h2 && hwrite && haddr[9:2] == 8'h1e;
  // shadow of the mixer word from the write data phase, then one edge late
  // so that it lines up with the registered routing pins
  logic mix_wr_q;
  logic [15:0] mix_shadow;
  logic [15:0] mix_seen;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mix_wr_q <= 1'b0;
      mix_shadow <= 16'h0000;
      mix_seen <= 16'h0000;
    end else begin
      mix_wr_q <= hsel && hready && htrans == 2'h2 && hwrite && haddr[9:2] == 8'h35;
      if (mix_wr_q) begin
        mix_shadow <= hwdata[15:0];
      end
      mix_seen <= mix_shadow;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_write_lands: assert property (vol_wr ##1 1'b1 |-> ##2
    (line2_atten_step == $past(hwdata[0], 2) && line2_neg_leg_mute == $past(hwdata[2], 2)
    && line2_pos_leg_mute == $past(hwdata[1], 2)))
    else $error("volume word did not reach the pins");
  a_mix_routes: assert property ({line2_ended_select, right_mix_to_neg_leg,
      left_mix_to_neg_leg, left_amp_to_diff_out, right_amp_to_diff_out,
      right_mix_to_diff, right_mix_to_pos_leg} ==
    {mix_seen[4], mix_seen[6:5] & {2{mix_seen[4]}}, mix_seen[2:1] & {2{!mix_seen[4]}},
      mix_seen[0] & !mix_seen[4], mix_seen[0] & mix_seen[4]})
    else $error("mixer routing does not follow the written word");
  a_neg_mode: assert property ((right_mix_to_neg_leg || left_mix_to_neg_leg)
    |-> line2_ended_select) else $error("negative leg routed in differential mode");
  a_amp_mode: assert property ((left_amp_to_diff_out || right_amp_to_diff_out)
    |-> !line2_ended_select) else $error("input amp routed in single ended mode");
  a_bit0_split: assert property (!(right_mix_to_diff && right_mix_to_pos_leg))
    else $error("right mixer routed both ways");
  a_rail_pump: assert property (pump_high_rail |-> pump_on)
    else $error("high rail with pump off");
  a_clk_off: assert property (!pump_on [*3] |-> !pump_clk)
    else $error("pump clock runs while pump off");
  // pump switching off mid pulse is allowed to cut the high phase short
  a_clk_high: assert property ($rose(pump_clk) |->
    (pump_clk [*8] ##1 !pump_clk) or (##[0:8] !pump_on)) else $error("pump clock period");
  cover property (right_mix_to_pos_leg);
  cover property (pump_high_rail && pump_clk);
  cover property (left_amp_to_diff_out && right_amp_to_diff_out);
endmodule
bind lopc_top lopc_sva u_lopc_sva (.*);

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  logic [7:0] dac_level = 8'h0;
  wire [31:0] hrdata;
  wire [12:0] pins;
  wire hreadyout, hresp, hi_rail, pclk;
  int n_errors = 0, samples_checked = 0, k;
  logic [15:0] m [int];
  logic [15:0] mk [int];
  lopc_top u_lopc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dac_level(dac_level),
    .line2_neg_leg_mute(pins[12]), .line2_pos_leg_mute(pins[11]), .line2_atten_step(pins[10]),
    .line2_ended_select(pins[9]), .right_mix_to_neg_leg(pins[8]), .left_mix_to_neg_leg(pins[7]),
    .left_amp_to_diff_out(pins[6]), .right_amp_to_diff_out(pins[5]),
    .right_mix_to_diff(pins[4]), .right_mix_to_pos_leg(pins[3]), .pump_on(pins[2]),
    .pump_high_rail(hi_rail), .pump_clk(pclk), .left_phones_driver_on(pins[1]),
    .right_phones_driver_on(pins[0]));
  initial begin
    forever #5 hclk = ~hclk;
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait for hready; running out ends the run
  task automatic hs;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_errors++;
      wrap_up;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hs;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hs;
    r = hrdata;
    if (w && m.exists(a)) m[a] = d[15:0] & mk[a];
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'h0, a, 32'h0);
    check("readback", r, m.exists(a) ? {16'h0, m[a]} : 32'h0);
  endtask
  // pins follow the register one edge after the data phase
  task automatic pc;
    logic [15:0] v, x, h;
    v = m[32'h78];
    x = m[32'hd4];
    h = m[32'h380];
    repeat (2) @(posedge hclk);
    #1;
    check("pins", pins, {v[2:0], x[4], x[6:5] & {2{x[4]}}, x[2:1] & {2{!x[4]}},
      x[0] & !x[4], x[0] & x[4], m[32'h130][15], h[6], h[14]});
  endtask
  // bounded wait for the pump clock to leave a level; looks after the edge settles
  task automatic wpc(input logic v);
    k = 0;
    while (pclk === v && k < 64) begin
      @(posedge hclk);
      #1;
      k++;
    end
    if (k >= 64) begin
      n_errors++;
      wrap_up;
    end
  endtask
  // reset held 8 edges, model back to reset values
  task automatic rst;
    m[32'h78] = 16'h0006;
    m[32'hd4] = 16'h0000;
    m[32'h130] = 16'h1f25;
    m[32'h144] = 16'h0000;
    m[32'h380] = 16'h0000;
    hresetn <= 1'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
  endtask
  initial begin
    mk[32'h78] = 16'h0007;
    mk[32'hd4] = 16'h0077;
    mk[32'h130] = 16'hffff;
    mk[32'h144] = 16'h0001;
    mk[32'h380] = 16'h7f7f;
    k = $urandom(41);
    rst;
    foreach (m[a]) rd(a);
    rd(32'h3fc);
    pc;
    $display("reset test done");
    repeat (12) begin
      bus(1'h1, 32'h78, $urandom);
      bus(1'h1, 32'hd4, $urandom);
      rd(32'hd4);
      rd(32'h78);
      pc;
    end
    bus(1'h1, 32'h3fc, 32'hffff);
    rd(32'h3fc);
    $display("routing test done");
    // low fifteen bits kept at their default on every toggle
    bus(1'h1, 32'h130, 32'h9f25);
    pc;
    wpc(1'h1);
    wpc(1'h0);
    wpc(1'h1);
    check("clk high", k, 32'h8);
    $display("pump clock test done");
    // dynamic control only with no analogue path into the outputs
    bus(1'h1, 32'hd4, 32'h0);
    // each step puts volume and dac level on opposite sides of the threshold
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 32'h144, i[1]);
      bus(1'h1, 32'h380, i[0] ? 32'h7f7f : 32'h4040);
      dac_level <= i[0] ? 8'h3f : 8'h40;
      pc;
      repeat (6) @(posedge hclk);
      #1;
      check("rail", hi_rail, i[0] ^ i[1]);
    end
    bus(1'h1, 32'h130, 32'h1f25);
    rd(32'h130);
    pc;
    repeat (4) @(posedge hclk);
    #1;
    check("clk off", pclk, 32'h0);
    $display("pump level test done");
    // reset in mid run on the edge that switches the pump on, before it runs, with the mixer word cleared
    bus(1'h1, 32'h130, 32'h9f25);
    rst;
    foreach (m[a]) rd(a);
    pc;
    check("clk reset", pclk, 32'h0);
    $display("mid run reset test done");
    wrap_up;
  end
endmodule
